// ==== rtl/level_dac_update_control.sv ====
// level dac bank update control: queueing, load strobes, launch delay, deglitch and coefficient pick
`timescale 1ns/1ps

// Operation
// (R1) Twenty-four 16-bit DACs held as two banks of twelve, written per channel.
// (R2) Host writes a DAC register address together with the target channel bits.
// (R3) Each bank has its own deferred update select bit in the control register.
// (R4) Immediate bank: valid DAC write starts update after chip select releases.
// (R5) Updates apply whole bank; queued deferred codes are applied too, never lost.
// (R6) Load strobe has no effect on a bank in immediate mode.
// (R7) Deferred bank: DAC write only queues the code, output stays unchanged.
// (R8) Deferred bank: load strobe applies all queued codes as one update.
// (R9) Shared DACs update as members of the bank they are assigned to.
// (R10) Dual-channel write: each bank follows its own update mode.
// (R11) One chip-wide deglitch timer of about 3 us gates all DACs of both banks.
// (R12) A new update during deglitch restarts the timer.
// (R13) Dual-bank immediate write starts deglitch only once, after both banks load.
// (R14) Outputs change after deglitch expires; settling takes about 7 us more.
// (R15) Update sequence begins four serial clocks after chip select release.
// (R16) Host writes overvoltage high level on channel 0, then loads channel 1.
// (R17) Overvoltage high level is applied only by a channel-1 load strobe; code also applies it on a channel-1 DAC write to immediate bank 1.
// (R18) Compare-high coefficient: window, differential or voltage measurement by settings.
// (R19) Current ranges pick own gain coefficient; all ranges share one offset.
// (R20) Per-channel registers stored per channel, selected by the two channel bits.
// (R21) Channel-0-only bits ignore channel-1 writes; dual writes act as channel 0.
// (R22) Load strobe is a one-cycle pulse per write of one.
module level_dac_update_control
  import level_dac_pkg::*;
(
  input wire logic core_clk, // 250 MHz core clock
  input wire logic resetn, // asynchronous reset, active low
  input wire logic wr_valid, // one-cycle pulse: decoded spi write
  input wire logic [1:0] wr_ch, // channel bits of the frame, bit0 = channel 0
  input wire logic [ADDR_W-1:0] wr_addr, // register address of the frame
  input wire logic [DATA_W-1:0] wr_data, // data word of the frame
  input wire logic cs_release, // one-cycle pulse: chip select released
  input wire logic sclk_tick, // one-cycle pulse per serial clock period
  input wire logic [1:0] diff_compare_enable, // per channel differential compare
  input wire logic [1:0] meas_unit_power, // per channel measure unit powered
  input wire logic [1:0] meas_current_select, // per channel measure current
  input wire logic [2:0] meas_range_code_ch0, // channel 0 current range code
  input wire logic [2:0] meas_range_code_ch1, // channel 1 current range code
  output logic [1:0] deferred_update_select, // per bank deferred mode bit
  output logic [BANK_DACS*DATA_W-1:0] level_codes_bank0, // codes driven to bank 0 dacs
  output logic [BANK_DACS*DATA_W-1:0] level_codes_bank1, // codes driven to bank 1 dacs
  output logic update_pending, // update armed, waiting for serial clocks
  output logic deglitch_active, // deglitch interval running
  output logic settling, // post-deglitch settling interval running
  output logic [2:0] m_coef_sel_ch0, // gain coefficient pick, channel 0
  output logic [2:0] c_coef_sel_ch0, // offset coefficient pick, channel 0
  output logic [2:0] m_coef_sel_ch1, // gain coefficient pick, channel 1
  output logic [2:0] c_coef_sel_ch1 // offset coefficient pick, channel 1
);

  // ****************************************
  // storage and state
  // ****************************************
  logic [DATA_W-1:0] pend_reg [NUM_BANKS][BANK_DACS]; // queued codes
  logic [DATA_W-1:0] applied_reg [NUM_BANKS][BANK_DACS]; // codes latched at launch
  logic [DATA_W-1:0] out_reg [NUM_BANKS][BANK_DACS]; // codes seen by the dacs
  logic [1:0] defer_reg;
  logic [1:0] frame_req_reg;
  logic [1:0] armed_reg;
  logic [LAUNCH_W-1:0] launch_cnt_reg;
  logic [DEG_CNT_W-1:0] deglitch_cnt_reg;
  logic [SET_CNT_W-1:0] settle_cnt_reg;
  logic [2:0] m_sel_reg [NUM_BANKS];
  logic [2:0] c_sel_reg [NUM_BANKS];

  // ****************************************
  // write decode
  // ****************************************
  logic dac_addr_hit;
  logic overvoltage_detect_high_level_hit;
  logic ctrl_hit;
  logic [SLOT_W-1:0] wr_slot;
  logic [1:0] dac_wr;
  logic [1:0] strobe_hit;
  logic [1:0] frame_req_set;
  logic apply_pulse;
  logic deglitch_done;

  assign dac_addr_hit = wr_valid && (wr_addr >= DAC_ADDR_FIRST) && (wr_addr <= DAC_ADDR_LAST);
  // (R21) channel-0-only register
  assign overvoltage_detect_high_level_hit = dac_addr_hit && (wr_addr == OVERVOLTAGE_DETECT_HIGH_LEVEL_ADDR) && wr_ch[0];
  assign ctrl_hit = wr_valid && (wr_addr == DAC_CTRL_ADDR);
  assign wr_slot = SLOT_W'(wr_addr - DAC_ADDR_FIRST);
  // (R20) per channel selection
  // the overvoltage high code is a channel-0-only address, so it never counts as a bank 1 write
  assign dac_wr[0] = dac_addr_hit && wr_ch[0];
  assign dac_wr[1] = dac_addr_hit && wr_ch[1] && (wr_addr != OVERVOLTAGE_DETECT_HIGH_LEVEL_ADDR);
  // (R22) load strobe pulse
  assign strobe_hit = ctrl_hit && wr_data[LOAD_BIT] ? wr_ch : 2'h0;

  // update requests raised by this frame, per bank
  always_comb begin
    for (int b = 0; b < NUM_BANKS; b++) begin
      // (R4) immediate write request
      // (R7) deferred write only queues
      // (R6) strobe ignored when immediate
      // (R8) strobe loads deferred bank
      // (R10) each bank by own mode
      frame_req_set[b] = (dac_wr[b] && !defer_reg[b]) || (strobe_hit[b] && defer_reg[b]);
    end
  end

  // ****************************************
  // mode bits
  // ****************************************
  // (R3) per bank deferred select
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      defer_reg <= DEFER_RST;
    end else if (ctrl_hit) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        if (wr_ch[b]) begin
          defer_reg[b] <= wr_data[DEFER_BIT];
        end
      end
    end
  end

  assign deferred_update_select = defer_reg;

  // ****************************************
  // pending queue
  // ****************************************
  // (R1) two banks of twelve codes
  // (R9) shared dac stored in its bank
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        for (int i = 0; i < BANK_DACS; i++) begin
          pend_reg[b][i] <= CODE_RST;
        end
      end
    end else if (overvoltage_detect_high_level_hit) begin
      // (R17) overvoltage high joins bank 1
      pend_reg[OVERVOLTAGE_DETECT_HIGH_LEVEL_BANK][OVERVOLTAGE_DETECT_HIGH_LEVEL_SLOT] <= wr_data;
    end else begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        if (dac_wr[b]) begin
          pend_reg[b][wr_slot] <= wr_data;
        end
      end
    end
  end

  // ****************************************
  // frame requests and launch delay
  // ****************************************
  // a request raised in the release cycle itself is folded straight into the armed set
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      frame_req_reg <= 2'h0;
    end else if (cs_release) begin
      frame_req_reg <= 2'h0;
    end else begin
      frame_req_reg <= frame_req_reg | frame_req_set;
    end
  end

  // (R15) launch after four serial clocks
  // a second release that carries new requests before launch merges banks and restarts the count
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      armed_reg <= 2'h0;
      launch_cnt_reg <= '0;
    end else if (cs_release && ((frame_req_reg | frame_req_set) != 2'h0)) begin
      armed_reg <= armed_reg | frame_req_reg | frame_req_set;
      launch_cnt_reg <= '0;
    end else if (apply_pulse) begin
      armed_reg <= 2'h0;
      launch_cnt_reg <= '0;
    end else if (armed_reg != 2'h0 && sclk_tick) begin
      launch_cnt_reg <= launch_cnt_reg + LAUNCH_W'(1);
    end
  end

  // launch only needs the serial clock to keep running after the frame
  assign apply_pulse = (armed_reg != 2'h0) && sclk_tick && !cs_release
                       && (launch_cnt_reg == LAUNCH_W'(LAUNCH_SCLK - 1));
  assign update_pending = armed_reg != 2'h0;

  // ****************************************
  // bank apply
  // ****************************************
  // (R5) whole bank, queued codes included
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        for (int i = 0; i < BANK_DACS; i++) begin
          applied_reg[b][i] <= CODE_RST;
        end
      end
    end else if (apply_pulse) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        if (armed_reg[b]) begin
          applied_reg[b] <= pend_reg[b];
        end
      end
    end
  end

  // ****************************************
  // deglitch and settling timers
  // ****************************************
  // (R11) single chip-wide deglitch timer
  // (R12) retrigger restarts the interval
  // (R13) one trigger for both banks
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      deglitch_cnt_reg <= '0;
    end else if (apply_pulse) begin
      deglitch_cnt_reg <= DEG_CNT_W'(DEGLITCH_CYCLES);
    end else if (deglitch_cnt_reg != '0) begin
      deglitch_cnt_reg <= deglitch_cnt_reg - DEG_CNT_W'(1);
    end
  end

  assign deglitch_done = deglitch_cnt_reg == DEG_CNT_W'(1) && !apply_pulse;
  assign deglitch_active = deglitch_cnt_reg != '0;

  // settling is reported only; the analog part settles on its own
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      settle_cnt_reg <= '0;
    end else if (apply_pulse) begin
      settle_cnt_reg <= '0;
    end else if (deglitch_done) begin
      settle_cnt_reg <= SET_CNT_W'(SETTLE_CYCLES);
    end else if (settle_cnt_reg != '0) begin
      settle_cnt_reg <= settle_cnt_reg - SET_CNT_W'(1);
    end
  end
  assign settling = settle_cnt_reg != '0;

  // (R14) outputs move at deglitch expiry
  // both banks move together since the gate is shared by every physical dac
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        for (int i = 0; i < BANK_DACS; i++) begin
          out_reg[b][i] <= CODE_RST;
        end
      end
    end else if (deglitch_done) begin
      out_reg <= applied_reg;
    end
  end

  for (genvar i = 0; i < BANK_DACS; i++) begin : g_out
    assign level_codes_bank0[i*DATA_W +: DATA_W] = out_reg[0][i];
    assign level_codes_bank1[i*DATA_W +: DATA_W] = out_reg[1][i];
  end

  // ****************************************
  // coefficient pair selection
  // ****************************************
  logic [2:0] range_code [NUM_BANKS];
  assign range_code[0] = meas_range_code_ch0;
  assign range_code[1] = meas_range_code_ch1;

  // (R18) compare-high coefficient pick
  // (R19) per-range gain, shared offset
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        m_sel_reg[b] <= COEF_WINDOW;
        c_sel_reg[b] <= COEF_WINDOW;
      end
    end else begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        if (!meas_unit_power[b]) begin
          m_sel_reg[b] <= diff_compare_enable[b] ? COEF_DIFF : COEF_WINDOW;
          c_sel_reg[b] <= diff_compare_enable[b] ? COEF_DIFF : COEF_WINDOW;
        end else if (!meas_current_select[b]) begin
          m_sel_reg[b] <= COEF_MEAS_V;
          c_sel_reg[b] <= COEF_MEAS_V;
        end else begin
          c_sel_reg[b] <= COEF_RANGE_ALL;
          case (range_code[b])
            RANGE_CODE_A: m_sel_reg[b] <= COEF_RANGE_A;
            RANGE_CODE_B: m_sel_reg[b] <= COEF_RANGE_B;
            RANGE_CODE_C: m_sel_reg[b] <= COEF_RANGE_C;
            RANGE_CODE_D: m_sel_reg[b] <= COEF_RANGE_D;
            default: m_sel_reg[b] <= COEF_RANGE_E;
          endcase
        end
      end
    end
  end

  assign m_coef_sel_ch0 = m_sel_reg[0];
  assign c_coef_sel_ch0 = c_sel_reg[0];
  assign m_coef_sel_ch1 = m_sel_reg[1];
  assign c_coef_sel_ch1 = c_sel_reg[1];

  // ****************************************
  // assertions
  // ****************************************
  property p_defer_queue_only;
    @(posedge core_clk) disable iff (!resetn)
    (dac_wr[0] && defer_reg[0] && !strobe_hit[0] && !frame_req_reg[0]) |=> !frame_req_reg[0];
  endproperty
  a_defer_queue_only: assert property (p_defer_queue_only) else $error("deferred write raised a request"); // R7

  property p_immediate_request;
    @(posedge core_clk) disable iff (!resetn)
    (dac_wr[1] && !defer_reg[1] && !cs_release) |=> frame_req_reg[1];
  endproperty
  a_immediate_request: assert property (p_immediate_request) else $error("immediate write not requested"); // R4

  property p_strobe_ignored;
    @(posedge core_clk) disable iff (!resetn)
    (strobe_hit[1] && !defer_reg[1] && !dac_wr[1] && !frame_req_reg[1] && !cs_release) |=> !frame_req_reg[1];
  endproperty
  a_strobe_ignored: assert property (p_strobe_ignored) else $error("strobe acted on immediate bank"); // R6

  property p_launch_four;
    @(posedge core_clk) disable iff (!resetn)
    $rose(update_pending) |-> (!apply_pulse)[*3];
  endproperty
  a_launch_four: assert property (p_launch_four) else $error("launch before four serial clocks"); // R15

  property p_launch_count;
    @(posedge core_clk) disable iff (!resetn)
    (update_pending && !sclk_tick) |=> update_pending;
  endproperty
  a_launch_count: assert property (p_launch_count) else $error("armed update launched without a serial clock"); // R15

  property p_deglitch_restart;
    @(posedge core_clk) disable iff (!resetn)
    apply_pulse |=> deglitch_cnt_reg == DEG_CNT_W'(DEGLITCH_CYCLES) && !update_pending;
  endproperty
  a_deglitch_restart: assert property (p_deglitch_restart) else $error("deglitch not restarted"); // R12

  property p_outputs_held;
    @(posedge core_clk) disable iff (!resetn)
    (deglitch_active && !deglitch_done) |=> $stable(level_codes_bank0) && $stable(level_codes_bank1);
  endproperty
  a_outputs_held: assert property (p_outputs_held) else $error("dac output moved during deglitch"); // R14

  property p_settle_follows;
    @(posedge core_clk) disable iff (!resetn)
    deglitch_done |=> settling && !deglitch_active;
  endproperty
  a_settle_follows: assert property (p_settle_follows) else $error("settling did not follow deglitch"); // R14

  property p_coef_diff;
    @(posedge core_clk) disable iff (!resetn)
    (!meas_unit_power[0] && diff_compare_enable[0]) |=> m_coef_sel_ch0 == COEF_DIFF;
  endproperty
  a_coef_diff: assert property (p_coef_diff) else $error("differential coefficient not picked"); // R18

  property p_coef_range;
    @(posedge core_clk) disable iff (!resetn)
    (meas_unit_power[1] && meas_current_select[1] && meas_range_code_ch1 == RANGE_CODE_D)
      |=> m_coef_sel_ch1 == COEF_RANGE_D && c_coef_sel_ch1 == COEF_RANGE_ALL;
  endproperty
  a_coef_range: assert property (p_coef_range) else $error("range coefficient wrong"); // R19

  property p_ch1_only_ignored;
    @(posedge core_clk) disable iff (!resetn)
    (wr_valid && wr_addr == OVERVOLTAGE_DETECT_HIGH_LEVEL_ADDR && wr_ch == 2'h2) |=> $stable(pend_reg[OVERVOLTAGE_DETECT_HIGH_LEVEL_BANK][OVERVOLTAGE_DETECT_HIGH_LEVEL_SLOT]);
  endproperty
  a_ch1_only_ignored: assert property (p_ch1_only_ignored) else $error("channel 1 write took effect"); // R21

endmodule

// ==== rtl/level_dac_pkg.sv ====
// constants for the level dac update control block
package level_dac_pkg;

  // ****************************************
  // widths and bank layout
  // ****************************************
  localparam int DATA_W = 16;
  localparam int BANK_DACS = 12;
  localparam int ADDR_W = 7;
  localparam int SLOT_W = 4;
  localparam int NUM_BANKS = 2;

  // ****************************************
  // spi register addresses and fields
  // ****************************************
  localparam logic [6:0] DAC_ADDR_FIRST = 7'h01;
  localparam logic [6:0] DAC_ADDR_LAST = 7'h0c;
  localparam logic [6:0] OVERVOLTAGE_DETECT_HIGH_LEVEL_ADDR = 7'h0c; // written on channel 0, member of bank 1
  localparam logic [3:0] OVERVOLTAGE_DETECT_HIGH_LEVEL_SLOT = 4'hb;
  localparam logic [0:0] OVERVOLTAGE_DETECT_HIGH_LEVEL_BANK = 1'h1;
  localparam logic [6:0] DAC_CTRL_ADDR = 7'h11;
  localparam int DEFER_BIT = 1;
  localparam int LOAD_BIT = 2;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [15:0] CODE_RST = 16'h0000;
  localparam logic [1:0] DEFER_RST = 2'h0;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int DEGLITCH_NS = 3000;
  localparam int SETTLE_NS = 7000;
  localparam int DEGLITCH_CYCLES = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEG_CNT_W = $clog2(DEGLITCH_CYCLES + 1);
  localparam int SET_CNT_W = $clog2(SETTLE_CYCLES + 1);
  localparam int LAUNCH_SCLK = 4;
  localparam int LAUNCH_W = 3;

  // ****************************************
  // coefficient pair selection codes
  // ****************************************
  localparam logic [2:0] COEF_WINDOW = 3'h0;
  localparam logic [2:0] COEF_DIFF = 3'h1;
  localparam logic [2:0] COEF_MEAS_V = 3'h2;
  localparam logic [2:0] COEF_RANGE_A = 3'h3;
  localparam logic [2:0] COEF_RANGE_B = 3'h4;
  localparam logic [2:0] COEF_RANGE_C = 3'h5;
  localparam logic [2:0] COEF_RANGE_D = 3'h6;
  localparam logic [2:0] COEF_RANGE_E = 3'h7;
  localparam logic [2:0] COEF_RANGE_ALL = 3'h3; // offset shared by every current range
  localparam logic [2:0] RANGE_CODE_A = 3'h7;
  localparam logic [2:0] RANGE_CODE_B = 3'h6;
  localparam logic [2:0] RANGE_CODE_C = 3'h5;
  localparam logic [2:0] RANGE_CODE_D = 3'h4;

endpackage

// ==== verification/host_spi_model.sv ====
// host side model: register writes, frame ends and serial clock ticks
`timescale 1ns/1ps
module host_spi_model
  import level_dac_pkg::*;
(
  input wire logic core_clk, // core clock
  output logic wr_valid, // decoded write pulse
  output logic [1:0] wr_ch, // channel bits of the write
  output logic [ADDR_W-1:0] wr_addr, // register address
  output logic [DATA_W-1:0] wr_data, // data word
  output logic cs_release, // frame end pulse
  output logic sclk_tick // serial clock tick
);
  // idle: serial clock stands still until ticks are requested
  initial begin
    wr_valid = 1'b0;
    wr_ch = 2'h0;
    wr_addr = 7'h00;
    wr_data = 16'h0000;
    cs_release = 1'b0;
    sclk_tick = 1'b0;
  end

  // address and channel go out together
  task automatic wr(input logic [1:0] ch, input logic [6:0] a, input logic [15:0] d);
    @(negedge core_clk);
    wr_valid = 1'b1;
    wr_ch = ch;
    wr_addr = a;
    wr_data = d;
    @(negedge core_clk);
    wr_valid = 1'b0;
    // released lines show the inverse so a stale copy cannot pass
    wr_ch = ~wr_ch;
    wr_addr = ~wr_addr;
    wr_data = ~wr_data;
  endtask

  // chip select release, one cycle
  task automatic rel();
    @(negedge core_clk);
    cs_release = 1'b1;
    @(negedge core_clk);
    cs_release = 1'b0;
  endtask

  // serial clock ticks only on request, one idle cycle between ticks
  task automatic ticks(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge core_clk);
      sclk_tick = 1'b1;
      @(negedge core_clk);
      sclk_tick = 1'b0;
    end
  endtask
endmodule

// ==== verification/tb_top.sv ====
// self-checking bench for the level dac update control block
`timescale 1ns/1ps
module tb_top;
  import level_dac_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic wr_valid, cs_release, sclk_tick;
  logic [1:0] wr_ch;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [1:0] diff_compare_enable = 2'h0;
  logic [1:0] meas_unit_power = 2'h0;
  logic [1:0] meas_current_select = 2'h0;
  logic [2:0] meas_range_code_ch0 = 3'h0;
  logic [2:0] meas_range_code_ch1 = 3'h0;
  logic [1:0] deferred_update_select;
  logic [BANK_DACS*DATA_W-1:0] level_codes_bank0, level_codes_bank1;
  logic update_pending, deglitch_active, settling;
  logic [2:0] m_coef_sel_ch0, c_coef_sel_ch0, m_coef_sel_ch1, c_coef_sel_ch1;
  int err_count = 0;
  int tests_run = 0;
  // settings row: diff, power, current, range[2:0], gain pick[2:0], offset pick[2:0]
  localparam logic [11:0] COEF_TBL [9] = '{12'h809, 12'h000, 12'hc12, 12'hfdb, 12'hfa3,
    12'hf6b, 12'hf33, 12'hefb, 12'he3b};

  // 4 ns clock
  always #2 core_clk = ~core_clk;

  level_dac_update_control i_dut (
    .core_clk, .resetn, .wr_valid, .wr_ch, .wr_addr, .wr_data, .cs_release, .sclk_tick,
    .diff_compare_enable, .meas_unit_power, .meas_current_select, .meas_range_code_ch0,
    .meas_range_code_ch1, .deferred_update_select, .level_codes_bank0, .level_codes_bank1,
    .update_pending, .deglitch_active, .settling, .m_coef_sel_ch0, .c_coef_sel_ch0,
    .m_coef_sel_ch1, .c_coef_sel_ch1
  );
  host_spi_model i_host (
    .core_clk, .wr_valid, .wr_ch, .wr_addr, .wr_data, .cs_release, .sclk_tick
  );

  // ****************************************
  // compare and helper tasks
  // ****************************************
  task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_b(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] slot(input logic [BANK_DACS*DATA_W-1:0] b, input int i);
    return b[16*i +: 16];
  endfunction

  // launch an armed update and time its deglitch; codes must hold meanwhile
  task automatic upd(input int exp_n);
    int n;
    logic [2*BANK_DACS*DATA_W-1:0] s0;
    n = 0;
    i_host.ticks(3);
    chk_b(update_pending, 1'b1);
    i_host.ticks(1);
    for (int k = 0; k < 3 && deglitch_active !== 1'b1; k++) @(negedge core_clk);
    s0 = {level_codes_bank0, level_codes_bank1};
    while (deglitch_active === 1'b1 && n < 4000) begin
      if (n == exp_n / 2) chk_b({level_codes_bank0, level_codes_bank1} === s0, 1'b1);
      n++;
      @(negedge core_clk);
    end
    chk_w(16'(n), 16'(exp_n));
    chk_b(settling, 1'b1);
  endtask

  // frame end with no update expected
  task automatic noupd();
    i_host.ticks(4);
    repeat (2) @(negedge core_clk);
    chk_b(deglitch_active, 1'b0);
    chk_b(update_pending, 1'b0);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  // reset state
  task automatic t_reset();
    chk_w(slot(level_codes_bank1, 11), CODE_RST);
    chk_w({14'h0, deferred_update_select}, {14'h0, DEFER_RST});
    chk_b(deglitch_active | update_pending | settling, 1'b0);
  endtask

  task automatic t_imm();
    i_host.wr(2'h3, 7'h01, 16'h1234);
    i_host.rel();
    upd(750);
    chk_w(slot(level_codes_bank0, 0), 16'h1234);
    chk_w(slot(level_codes_bank1, 0), 16'h1234);
    repeat (8) @(negedge core_clk);
    chk_b(deglitch_active, 1'b0);
  endtask

  task automatic t_retrig();
    i_host.wr(2'h1, 7'h05, 16'haaaa);
    i_host.rel();
    i_host.ticks(4);
    repeat (100) @(negedge core_clk);
    chk_b(deglitch_active, 1'b1);
    i_host.wr(2'h1, 7'h06, 16'h5555);
    i_host.rel();
    upd(750);
    chk_w(slot(level_codes_bank0, 4), 16'haaaa);
    chk_w(slot(level_codes_bank0, 5), 16'h5555);
  endtask

  task automatic t_defer();
    i_host.wr(2'h1, DAC_CTRL_ADDR, 16'h0002);
    @(negedge core_clk);
    chk_w({14'h0, deferred_update_select}, 16'h0001);
    i_host.wr(2'h3, 7'h02, 16'h1111);
    i_host.rel();
    upd(750);
    chk_w(slot(level_codes_bank0, 1), 16'h0000);
    chk_w(slot(level_codes_bank1, 1), 16'h1111);
    i_host.wr(2'h1, DAC_CTRL_ADDR, 16'h0006);
    i_host.rel();
    upd(750);
    chk_w(slot(level_codes_bank0, 1), 16'h1111);
    i_host.rel();
    noupd();
    i_host.wr(2'h1, 7'h03, 16'h2222);
    i_host.rel();
    noupd();
    i_host.wr(2'h1, DAC_CTRL_ADDR, 16'h0000);
    i_host.wr(2'h1, 7'h04, 16'h3333);
    i_host.rel();
    upd(750);
    chk_w(slot(level_codes_bank0, 2), 16'h2222);
    chk_w(slot(level_codes_bank0, 3), 16'h3333);
    i_host.wr(2'h2, DAC_CTRL_ADDR, 16'h0004);
    i_host.rel();
    noupd();
  endtask

  // overvoltage high level follows the channel-1 strobe
  task automatic t_overvoltage_detect_high_level();
    int n;
    i_host.wr(2'h3, DAC_CTRL_ADDR, 16'h0002);
    i_host.wr(2'h1, OVERVOLTAGE_DETECT_HIGH_LEVEL_ADDR, 16'hbeef);
    i_host.wr(2'h1, DAC_CTRL_ADDR, 16'h0006);
    i_host.rel();
    upd(750);
    chk_w(slot(level_codes_bank1, 11), 16'h0000);
    // a channel-1-only write to the channel-0-only address must be dropped
    i_host.wr(2'h2, OVERVOLTAGE_DETECT_HIGH_LEVEL_ADDR, 16'h1357);
    i_host.wr(2'h2, DAC_CTRL_ADDR, 16'h0006);
    i_host.rel();
    upd(750);
    chk_w(slot(level_codes_bank1, 11), 16'hbeef);
    chk_w(slot(level_codes_bank0, 11), 16'h0000);
    // settling window length after the last deglitch expiry
    n = 0;
    while (settling === 1'b1 && n < 4000) begin
      n++;
      @(negedge core_clk);
    end
    chk_w(16'(n), 16'h06d6);
  endtask

  // coefficient pair pick across every mode and range
  task automatic t_coef();
    for (int i = 0; i < 9; i++) begin
      @(negedge core_clk);
      // channel 1 runs one row ahead so a swapped channel cannot pass
      diff_compare_enable = {COEF_TBL[(i + 1) % 9][11], COEF_TBL[i][11]};
      meas_unit_power = {COEF_TBL[(i + 1) % 9][10], COEF_TBL[i][10]};
      meas_current_select = {COEF_TBL[(i + 1) % 9][9], COEF_TBL[i][9]};
      meas_range_code_ch0 = COEF_TBL[i][8:6];
      meas_range_code_ch1 = COEF_TBL[(i + 1) % 9][8:6];
      repeat (2) @(negedge core_clk);
      chk_w({10'h0, m_coef_sel_ch0, c_coef_sel_ch0}, {10'h0, COEF_TBL[i][5:0]});
      chk_w({10'h0, m_coef_sel_ch1, c_coef_sel_ch1}, {10'h0, COEF_TBL[(i + 1) % 9][5:0]});
    end
  endtask

  // ****************************************
  // run control
  // ****************************************
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // main sequence: two cycles of reset, then every scenario
  initial begin
    repeat (2) @(negedge core_clk);
    resetn = 1'b1;
    t_reset();
    t_imm();
    t_retrig();
    t_defer();
    t_overvoltage_detect_high_level();
    t_coef();
    print_verdict();
  end

  // watchdog: about four times the expected run of some 7300 cycles
  initial begin
    #120000;
    err_count++;
    $display("watchdog expired");
    print_verdict();
  end
endmodule
